/* File: src/pssc_pkg.sv */
// constants, register map and state type of the power, sleep and shutdown control block.
// assumes a 200 MHz mclk and an 8-bit register port fed by the control-port decoder.
package pssc_pkg;

	// mclk cycles per microsecond
	localparam int unsigned CLK_MHZ = 200;

	// register offsets
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
	localparam logic [7:0] ADDR_SLEEP_CFG  = 8'h02;
	localparam logic [7:0] ADDR_SHUTDOWN_CONFIG   = 8'h05;

	// reset values and writable-bit masks
	localparam logic [7:0] SOFT_RESET_RST  = 8'h00;
	localparam logic [7:0] SLEEP_CFG_RST   = 8'h00;
	localparam logic [7:0] SHUTDOWN_CONFIG_RST    = 8'h05;
	localparam logic [7:0] SLEEP_CFG_WMASK = 8'hFD;
	localparam logic [7:0] SHUTDOWN_CONFIG_WMASK  = 8'h3F;

	// field positions
	localparam int unsigned SOFT_RESET_BIT   = 0;
	localparam int unsigned AWAKE_BIT        = 0;
	localparam int unsigned SHARED_ADDR_BIT  = 2;
	localparam int unsigned VREF_LSB         = 3;
	localparam int unsigned ANALOG_SRC_BIT   = 7;
	localparam int unsigned HOLD_LSB         = 0;
	localparam int unsigned POLICY_LSB       = 2;
	localparam int unsigned INCAP_LSB        = 4;

	// power-down policy codes
	localparam logic [1:0] POLICY_IMMEDIATE = 2'h0;
	localparam logic [1:0] POLICY_TIMED     = 2'h1;
	localparam logic [1:0] POLICY_CLEAN     = 2'h2;

	// control-bus addresses
	localparam logic [6:0] SHARED_BUS_ADDR = 7'h4C;
	localparam logic [4:0] STRAP_ADDR_BASE = 5'h0A;
	localparam int unsigned STRAP_W        = 2;

	// pin synchroniser
	localparam int unsigned SYNC_W = STRAP_W + 1;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h1;

	// durations in microseconds, indexed by field code
	localparam int unsigned VREF_US  [4] = '{3500, 10000, 50000, 100000};
	localparam int unsigned INCAP_US [4] = '{2500, 12500, 25000, 50000};
	localparam int unsigned HOLD_US  [4] = '{30000, 25000, 10000, 5000};

	// durations in mclk cycles
	localparam int unsigned VREF_CYC  [4] = '{VREF_US[0] * CLK_MHZ, VREF_US[1] * CLK_MHZ,
		VREF_US[2] * CLK_MHZ, VREF_US[3] * CLK_MHZ};
	localparam int unsigned INCAP_CYC [4] = '{INCAP_US[0] * CLK_MHZ, INCAP_US[1] * CLK_MHZ,
		INCAP_US[2] * CLK_MHZ, INCAP_US[3] * CLK_MHZ};
	localparam int unsigned HOLD_CYC  [4] = '{HOLD_US[0] * CLK_MHZ, HOLD_US[1] * CLK_MHZ,
		HOLD_US[2] * CLK_MHZ, HOLD_US[3] * CLK_MHZ};

	localparam int unsigned CNT_W = 25;

	typedef enum logic [2:0] {
		ST_SLEEP,
		ST_VREF,
		ST_INCAP,
		ST_ACTIVE,
		ST_HOLD_TIMED,
		ST_HOLD_CLEAN,
		ST_CORE_OFF
	} pssc_state_t;

endpackage

/* File: src/pssc_timer.sv */
// one-shot down-counter used for precharge and core-supply hold durations.
// assumes load is at least one; start and stop are single-cycle requests.
`timescale 1ns/100ps
module pssc_timer (
	input  wire logic   mclk,
	input  wire logic   rst,
	pssc_tmr_if.timer   tmr
);
	logic [pssc_pkg::CNT_W-1:0] count_reg;

	// stop wins over start so an aborted phase never leaves a stale count
	always_ff @(posedge mclk) begin
		if (rst || tmr.stop) begin
			count_reg <= '0;
		end else if (tmr.start) begin
			count_reg <= tmr.load;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	// done marks the last counted cycle, so a phase lasts exactly load cycles
	assign tmr.busy = (count_reg != '0);
	assign tmr.done = (count_reg == pssc_pkg::CNT_W'(1));
endmodule

/* File: src/pssc_tmr_if.sv */
// interface between the sequencer and its shared down-counter.
// assumes both ends run on the same mclk.
`timescale 1ns/100ps
interface pssc_tmr_if;
	logic                        start;
	logic                        stop;
	logic [pssc_pkg::CNT_W-1:0]  load;
	logic                        busy;
	logic                        done;

	modport ctrl (output start, output stop, output load, input busy, input done);
	modport timer (input start, input stop, input load, output busy, output done);
endinterface

/* File: src/pssc_top.sv */
// power, sleep and shutdown control: soft reset, sleep entry and exit with
// reference and input precharge, analog supply choice, control-bus address choice
// and the core regulator policy after the power-down pin asserts.
// assumes a same-clock register port from the control-port decoder, an asynchronous
// power-down pin and address straps, and a clean-shutdown flag from device logic.
//
// Operation
// - writing 1 to the soft reset bit starts a reset; bit reads back 0
// - soft reset returns every register to its power-on default
// - awake select resets to 0 and holds sleep; device wakes only while 1
// - analog source bit 7: 0 external rail, 1 on-chip regulator enabled
// - reference precharge code 0..3 gives 3.5, 10, 50, 100 ms
// - shared address enable answers fixed 1001100, otherwise address from straps
// - input precharge code 0..3 gives 2.5, 12.5, 25, 50 ms
// - policy 0 turns the core regulator off at once on power-down
// - policy 1 keeps core regulator on until clean shutdown or hold timeout
// - policy 2 keeps core regulator on until clean shutdown; code 3 reserved
// - hold time code 0..3 gives 30, 25, 10, 5 ms
// - shutdown register resets to 5h
`timescale 1ns/100ps
module pssc_top #(
	parameter int unsigned VREF_CYC  [4] = pssc_pkg::VREF_CYC,
	parameter int unsigned INCAP_CYC [4] = pssc_pkg::INCAP_CYC,
	parameter int unsigned HOLD_CYC  [4] = pssc_pkg::HOLD_CYC
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic                          reg_wr_en,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_rd_en,
	output logic      [7:0]                    reg_rdata,
	input  wire logic                          power_down_pin_n,
	input  wire logic [pssc_pkg::STRAP_W-1:0]  bus_id_strap,
	input  wire logic                          shutdown_done,
	output logic                               analog_regulator_en,
	output logic                               core_regulator_en,
	output logic                               device_awake,
	output logic                               vref_precharge_en,
	output logic                               incap_precharge_en,
	output logic                               shutdown_req,
	output logic      [6:0]                    bus_address
);

	function automatic logic [pssc_pkg::CNT_W-1:0] to_cnt(input int unsigned v);
		return v[pssc_pkg::CNT_W-1:0];
	endfunction

	// ---------------- pin synchronisers ----------------
	logic [pssc_pkg::SYNC_W-1:0] pin_raw;
	logic [pssc_pkg::SYNC_W-1:0] sync1_reg;
	logic [pssc_pkg::SYNC_W-1:0] sync2_reg;
	logic [pssc_pkg::SYNC_W-1:0] sync3_reg;
	logic [pssc_pkg::SYNC_W-1:0] pin_stable_reg;

	assign pin_raw = {bus_id_strap, power_down_pin_n};

	// a change is taken only when stages two and three agree, filtering one-cycle glitches
	genvar gi;
	generate
		for (gi = 0; gi < pssc_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					sync1_reg[gi]      <= pssc_pkg::SYNC_RST[gi];
					sync2_reg[gi]      <= pssc_pkg::SYNC_RST[gi];
					sync3_reg[gi]      <= pssc_pkg::SYNC_RST[gi];
					pin_stable_reg[gi] <= pssc_pkg::SYNC_RST[gi];
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						pin_stable_reg[gi] <= sync3_reg[gi];
					end
				end
			end
		end
	endgenerate

	logic                         power_down_active;
	logic [pssc_pkg::STRAP_W-1:0] strap_value;

	assign power_down_active = ~pin_stable_reg[0];
	assign strap_value       = pin_stable_reg[pssc_pkg::SYNC_W-1:1];

	// ---------------- register file ----------------
	logic       soft_reset_pending_reg;
	logic [7:0] sleep_and_supply_config_reg;
	logic [7:0] shutdown_config_reg;
	logic [7:0] reg_rdata_reg;
	logic       regs_rst;

	logic       hit_soft_reset;
	logic       hit_sleep_cfg;
	logic       hit_shutdown_config;

	assign hit_soft_reset = (reg_addr == pssc_pkg::ADDR_SOFT_RESET);
	assign hit_sleep_cfg  = (reg_addr == pssc_pkg::ADDR_SLEEP_CFG);
	assign hit_shutdown_config   = (reg_addr == pssc_pkg::ADDR_SHUTDOWN_CONFIG);

	// the pending flag lives one cycle, then resets the registers, read data, timer and sequencer including itself; pin filters and outputs reset on rst only
	assign regs_rst = rst | soft_reset_pending_reg;

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			soft_reset_pending_reg <= 1'b0;
		end else begin
			soft_reset_pending_reg <= reg_wr_en & hit_soft_reset
				& reg_wdata[pssc_pkg::SOFT_RESET_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			sleep_and_supply_config_reg <= pssc_pkg::SLEEP_CFG_RST;
			shutdown_config_reg         <= pssc_pkg::SHUTDOWN_CONFIG_RST;
		end else if (reg_wr_en && hit_sleep_cfg) begin
			sleep_and_supply_config_reg <= reg_wdata & pssc_pkg::SLEEP_CFG_WMASK;
		end else if (reg_wr_en && hit_shutdown_config) begin
			shutdown_config_reg <= reg_wdata & pssc_pkg::SHUTDOWN_CONFIG_WMASK;
		end
	end

	// read data appears one cycle after reg_rd_en; unmapped offsets read zero
	logic [7:0] read_mux;
	logic [7:0] soft_reset_view;

	assign soft_reset_view = pssc_pkg::SOFT_RESET_RST
		| {7'h00, soft_reset_pending_reg};

	always_comb begin
		if (hit_soft_reset) begin
			read_mux = soft_reset_view;
		end else if (hit_sleep_cfg) begin
			read_mux = sleep_and_supply_config_reg;
		end else if (hit_shutdown_config) begin
			read_mux = shutdown_config_reg;
		end else begin
			read_mux = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd_en) begin
			reg_rdata_reg <= read_mux;
		end
	end

	assign reg_rdata = reg_rdata_reg;

	// ---------------- field decode ----------------
	logic       awake_select;
	logic       analog_supply_source;
	logic       shared_bus_address_en;
	logic [1:0] reference_precharge_time;
	logic [1:0] input_cap_precharge_time;
	logic [1:0] power_down_policy;
	logic [1:0] core_supply_hold_time;

	assign awake_select             = sleep_and_supply_config_reg[pssc_pkg::AWAKE_BIT];
	assign analog_supply_source     = sleep_and_supply_config_reg[pssc_pkg::ANALOG_SRC_BIT];
	assign shared_bus_address_en    = sleep_and_supply_config_reg[pssc_pkg::SHARED_ADDR_BIT];
	assign reference_precharge_time =
		sleep_and_supply_config_reg[pssc_pkg::VREF_LSB +: 2];
	assign input_cap_precharge_time = shutdown_config_reg[pssc_pkg::INCAP_LSB +: 2];
	assign power_down_policy        = shutdown_config_reg[pssc_pkg::POLICY_LSB +: 2];
	assign core_supply_hold_time    = shutdown_config_reg[pssc_pkg::HOLD_LSB +: 2];

	logic [pssc_pkg::CNT_W-1:0] vref_load;
	logic [pssc_pkg::CNT_W-1:0] incap_load;
	logic [pssc_pkg::CNT_W-1:0] hold_load;

	assign vref_load  = to_cnt(VREF_CYC[reference_precharge_time]);
	assign incap_load = to_cnt(INCAP_CYC[input_cap_precharge_time]);
	assign hold_load  = to_cnt(HOLD_CYC[core_supply_hold_time]);

	// ---------------- sequencer ----------------
	pssc_tmr_if tmr ();

	pssc_timer u_timer (
		.mclk (mclk),
		.rst  (regs_rst),
		.tmr  (tmr)
	);

	pssc_pkg::pssc_state_t state_reg;
	pssc_pkg::pssc_state_t state_next;

	// the reserved policy code behaves as the immediate one: it never strands the supply on
	always_comb begin
		state_next = state_reg;
		tmr.start  = 1'b0;
		tmr.stop   = 1'b0;
		tmr.load   = vref_load;
		case (state_reg)
			pssc_pkg::ST_SLEEP, pssc_pkg::ST_VREF, pssc_pkg::ST_INCAP,
			pssc_pkg::ST_ACTIVE: begin
				if (power_down_active) begin
					tmr.stop = 1'b1;
					if (power_down_policy == pssc_pkg::POLICY_TIMED) begin
						state_next = pssc_pkg::ST_HOLD_TIMED;
					end else if (power_down_policy == pssc_pkg::POLICY_CLEAN) begin
						state_next = pssc_pkg::ST_HOLD_CLEAN;
					end else begin
						state_next = pssc_pkg::ST_CORE_OFF;
					end
				end else if (!awake_select) begin
					tmr.stop   = (state_reg != pssc_pkg::ST_SLEEP);
					state_next = pssc_pkg::ST_SLEEP;
				end else if (state_reg == pssc_pkg::ST_SLEEP) begin
					tmr.start  = 1'b1;
					tmr.load   = vref_load;
					state_next = pssc_pkg::ST_VREF;
				end else if (state_reg == pssc_pkg::ST_VREF && tmr.done) begin
					tmr.start  = 1'b1;
					tmr.load   = incap_load;
					state_next = pssc_pkg::ST_INCAP;
				end else if (state_reg == pssc_pkg::ST_INCAP && tmr.done) begin
					state_next = pssc_pkg::ST_ACTIVE;
				end
			end
			pssc_pkg::ST_HOLD_TIMED: begin
				if (shutdown_done || tmr.done) begin
					state_next = pssc_pkg::ST_CORE_OFF;
				end
			end
			pssc_pkg::ST_HOLD_CLEAN: begin
				if (shutdown_done) begin
					state_next = pssc_pkg::ST_CORE_OFF;
				end
			end
			pssc_pkg::ST_CORE_OFF: begin
				if (!power_down_active) begin
					state_next = pssc_pkg::ST_SLEEP;
				end
			end
			default: begin
				state_next = pssc_pkg::ST_SLEEP;
			end
		endcase
		// the hold counter starts on the cycle the policy leaves a running state
		if (state_next == pssc_pkg::ST_HOLD_TIMED && state_reg != pssc_pkg::ST_HOLD_TIMED) begin
			tmr.stop  = 1'b0;
			tmr.start = 1'b1;
			tmr.load  = hold_load;
		end
	end

	always_ff @(posedge mclk) begin
		if (regs_rst) begin
			state_reg <= pssc_pkg::ST_SLEEP;
		end else begin
			state_reg <= state_next;
		end
	end

	// ---------------- registered outputs ----------------
	logic       analog_regulator_en_reg;
	logic       core_regulator_en_reg;
	logic       device_awake_reg;
	logic       vref_precharge_en_reg;
	logic       incap_precharge_en_reg;
	logic       shutdown_req_reg;
	logic [6:0] bus_address_reg;
	logic [6:0] bus_address_next;
	logic       core_off_next;

	assign core_off_next    = (state_next == pssc_pkg::ST_CORE_OFF);
	assign bus_address_next = shared_bus_address_en ? pssc_pkg::SHARED_BUS_ADDR
		: {pssc_pkg::STRAP_ADDR_BASE, strap_value};

	// outputs other than bus_address follow state_next so they change on the same edge as the state
	always_ff @(posedge mclk) begin
		if (rst) begin
			analog_regulator_en_reg <= 1'b0;
			core_regulator_en_reg   <= 1'b1;
			device_awake_reg        <= 1'b0;
			vref_precharge_en_reg   <= 1'b0;
			incap_precharge_en_reg  <= 1'b0;
			shutdown_req_reg        <= 1'b0;
			bus_address_reg         <= {pssc_pkg::STRAP_ADDR_BASE, pssc_pkg::STRAP_W'(0)};
		end else begin
			analog_regulator_en_reg <= analog_supply_source & ~core_off_next;
			core_regulator_en_reg   <= ~core_off_next;
			device_awake_reg        <= (state_next == pssc_pkg::ST_ACTIVE);
			vref_precharge_en_reg   <= (state_next == pssc_pkg::ST_VREF);
			incap_precharge_en_reg  <= (state_next == pssc_pkg::ST_INCAP);
			shutdown_req_reg        <= (state_next == pssc_pkg::ST_HOLD_TIMED)
				| (state_next == pssc_pkg::ST_HOLD_CLEAN);
			bus_address_reg         <= bus_address_next;
		end
	end

	assign analog_regulator_en = analog_regulator_en_reg;
	assign core_regulator_en   = core_regulator_en_reg;
	assign device_awake        = device_awake_reg;
	assign vref_precharge_en   = vref_precharge_en_reg;
	assign incap_precharge_en  = incap_precharge_en_reg;
	assign shutdown_req        = shutdown_req_reg;
	assign bus_address         = bus_address_reg;

endmodule

/* File: testbench/pssc_host.sv */
// host model: drives the register strobe port of the block
// assumes strobes are sampled on the rising mclk edge
`timescale 1ns/100ps
module pssc_host (
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd_en
);
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
	end
	// released data is inverted so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge mclk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge mclk);
		reg_rd_en <= 1'b0;
		@(posedge mclk);
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: testbench/pssc_top_asserts.sv */
// checker for the power, sleep and shutdown control block
// assumes it is bound to pssc_top and sees only its ports
`timescale 1ns/100ps
module pssc_top_asserts #(
	parameter int unsigned VREF_CYC [4] = pssc_pkg::VREF_CYC
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [7:0] reg_rdata,
	input wire logic       power_down_pin_n,
	input wire logic       shutdown_done,
	input wire logic       analog_regulator_en,
	input wire logic       core_regulator_en,
	input wire logic       device_awake,
	input wire logic       vref_precharge_en,
	input wire logic       incap_precharge_en,
	input wire logic       shutdown_req,
	input wire logic [6:0] bus_address
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	int unsigned vcnt_reg;
	always_ff @(posedge mclk) begin
		if (rst || !vref_precharge_en) begin
			vcnt_reg <= 0;
		end else begin
			vcnt_reg <= vcnt_reg + 1;
		end
	end
	sequence s_hold_start;
		$rose(shutdown_req) ##0 !shutdown_done;
	endsequence
	sequence s_core_drop;
		$fell(core_regulator_en);
	endsequence
	a_rdata_after_reset: assert property ($fell(rst) |-> reg_rdata == 8'h00
		&& core_regulator_en && !device_awake) else $error("reset outputs wrong");
	a_core_off_cause: assert property (s_core_drop |-> !$past(power_down_pin_n))
		else $error("core off without power-down");
	a_core_off_quiet: assert property (s_core_drop |-> ##[0:2]
		(!device_awake && !analog_regulator_en)) else $error("awake with core off");
	a_awake_clean: assert property (device_awake |->
		!vref_precharge_en && !incap_precharge_en) else $error("awake while charging");
	a_precharge_excl: assert property (!(vref_precharge_en && incap_precharge_en))
		else $error("both precharges on");
	a_addr_legal: assert property (bus_address == pssc_pkg::SHARED_BUS_ADDR
		|| bus_address[6:2] == pssc_pkg::STRAP_ADDR_BASE) else $error("bad bus address");
	a_vref_bound: assert property (vcnt_reg <= VREF_CYC[3])
		else $error("reference precharge too long");
	a_hold_core_on: assert property (s_hold_start |=> core_regulator_en)
		else $error("core off at hold start");
endmodule
bind pssc_top pssc_top_asserts #(.VREF_CYC(VREF_CYC)) pssc_top_asserts_inst (
	.mclk(mclk), .rst(rst), .reg_rdata(reg_rdata), .power_down_pin_n(power_down_pin_n),
	.shutdown_done(shutdown_done), .analog_regulator_en(analog_regulator_en),
	.core_regulator_en(core_regulator_en), .device_awake(device_awake),
	.vref_precharge_en(vref_precharge_en), .incap_precharge_en(incap_precharge_en),
	.shutdown_req(shutdown_req), .bus_address(bus_address));

/* File: testbench/pssc_top_tb_top.sv */
// testbench for the power, sleep and shutdown control block
// assumes short counts are given to the top through its parameters
`timescale 1ns/100ps
module pssc_top_tb_top;
	localparam int unsigned VC [4] = '{20, 30, 40, 50};
	localparam int unsigned IC [4] = '{24, 34, 44, 54};
	localparam int unsigned HC [4] = '{90, 70, 50, 30};
	logic       mclk, rst, power_down_pin_n, shutdown_done, reg_wr_en, reg_rd_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] bus_id_strap;
	logic       analog_regulator_en, core_regulator_en, device_awake;
	logic       vref_precharge_en, incap_precharge_en, shutdown_req;
	logic [6:0] bus_address;
	int         n_errors, samples_checked;
	pssc_top #(.VREF_CYC(VC), .INCAP_CYC(IC), .HOLD_CYC(HC)) pssc_top_inst (.mclk(mclk),
		.rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
		.reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .power_down_pin_n(power_down_pin_n),
		.bus_id_strap(bus_id_strap), .shutdown_done(shutdown_done),
		.analog_regulator_en(analog_regulator_en), .core_regulator_en(core_regulator_en),
		.device_awake(device_awake), .vref_precharge_en(vref_precharge_en),
		.incap_precharge_en(incap_precharge_en), .shutdown_req(shutdown_req),
		.bus_address(bus_address));
	pssc_host pssc_host_inst (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return vref_precharge_en;
			1: return incap_precharge_en;
			2: return core_regulator_en;
			default: return device_awake;
		endcase
	endfunction
	// bounded wait; n is the number of cycles spent
	task automatic wait_for(input int s, input logic v, output int n);
		n = 0;
		while (sig(s) !== v && n < 400) begin
			step(1);
			n++;
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		pssc_host_inst.rd(a, d);
		chk("rdata", e, d);
	endtask
	task automatic t_defaults;
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h00);
		rdchk(8'h05, 8'h05);
		rdchk(8'h03, 8'h00);
		$display("test defaults done");
	endtask
	task automatic t_wake;
		int n;
		for (int c = 0; c < 4; c++) begin
			pssc_host_inst.wr(8'h05, 8'h05 | 8'(c << 4));
			pssc_host_inst.wr(8'h02, 8'h81 | 8'(c << 3));
			wait_for(0, 1'b1, n);
			wait_for(0, 1'b0, n);
			chk("vref_cycles", 8'(VC[c]), 8'(n));
			wait_for(1, 1'b1, n);
			wait_for(1, 1'b0, n);
			chk("incap_cycles", 8'(IC[c]), 8'(n));
			wait_for(3, 1'b1, n);
			chk("awake", 8'h01, {7'h00, device_awake});
			chk("analog_en", 8'h01, {7'h00, analog_regulator_en});
			pssc_host_inst.wr(8'h02, 8'h00);
			step(3);
			chk("asleep", 8'h00, {7'h00, device_awake});
			chk("analog_off", 8'h00, {7'h00, analog_regulator_en});
		end
		$display("test wake done");
	endtask
	task automatic t_address;
		pssc_host_inst.wr(8'h02, 8'h04);
		step(3);
		chk("shared_addr", 8'h4C, {1'b0, bus_address});
		pssc_host_inst.wr(8'h02, 8'h00);
		step(3);
		chk("strap_addr", {1'b0, pssc_pkg::STRAP_ADDR_BASE, 2'h2}, {1'b0, bus_address});
		// a strap change must pass the pin filter and reach the address
		@(posedge mclk);
		bus_id_strap <= 2'h1;
		step(6);
		chk("strap2", {1'b0, pssc_pkg::STRAP_ADDR_BASE, 2'h1}, {1'b0, bus_address});
		$display("test address done");
	endtask
	task automatic t_soft_reset;
		pssc_host_inst.wr(8'h05, 8'hFF);
		rdchk(8'h05, 8'h3F);
		pssc_host_inst.wr(8'h02, 8'hFF);
		rdchk(8'h02, 8'hFD);
		chk("sr_vref_on", 8'h01, {7'h00, vref_precharge_en});
		pssc_host_inst.wr(8'h01, 8'h01);
		step(4);
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h00);
		rdchk(8'h05, 8'h05);
		chk("sr_vref_off", 8'h00, {7'h00, vref_precharge_en});
		$display("test soft reset done");
	endtask
	task automatic t_power_down;
		int n;
		int h;
		int pol;
		// runs 0..3 time out with every hold code, then policies 0, 2 and reserved 3
		for (int i = 0; i < 7; i++) begin
			h = i % 4;
			pol = (i < 4) ? 1 : ((i == 4) ? 0 : i - 3);
			pssc_host_inst.wr(8'h05, 8'(h | (pol << 2)));
			@(posedge mclk);
			power_down_pin_n <= 1'b0;
			#1;
			if (pol == 2) begin
				// held well past the longest hold time: no timeout applies
				step(2 * HC[0]);
				chk("core_held", 8'h01, {7'h00, core_regulator_en});
				chk("shutdown_req", 8'h01, {7'h00, shutdown_req});
				@(posedge mclk);
				shutdown_done <= 1'b1;
				#1;
			end
			wait_for(2, 1'b0, n);
			if (pol == 0 || pol == 3) begin
				chk("immediate", 8'h01, {7'h00, n <= 8});
			end
			if (pol == 1) begin
				chk("timed", 8'h01, {7'h00, n >= HC[h] && n <= HC[h] + 8});
			end
			if (pol == 2) begin
				chk("clean", 8'h01, {7'h00, n <= 4});
			end
			@(posedge mclk);
			power_down_pin_n <= 1'b1;
			shutdown_done <= 1'b0;
			#1;
			wait_for(2, 1'b1, n);
			chk("core_back", 8'h01, {7'h00, core_regulator_en});
		end
		$display("test power down done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		n_errors = 0;
		samples_checked = 0;
		rst = 1'b1;
		power_down_pin_n = 1'b1;
		shutdown_done = 1'b0;
		bus_id_strap = 2'h2;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		step(4);
		t_defaults();
		t_wake();
		t_address();
		t_soft_reset();
		t_power_down();
		report_and_stop();
	end
endmodule
